//--- hdl/cos_pkg.sv
// operand streaming package: register map, field positions, instruction encodings
// assumes a byte-addressed register port and the 32-bit instruction word layout below
package cos_pkg;

	// =========================================================
	// register map (byte addresses)
	localparam logic [15:0] ADDR_LD0_STATE = 16'h0000;
	localparam logic [15:0] ADDR_LD1_STATE = 16'h0004;
	localparam logic [15:0] ADDR_ST_STATE  = 16'h0008;
	localparam logic [15:0] ADDR_WINDOW    = 16'h000C;
	localparam logic [15:0] ADDR_CTL       = 16'h0010;
	localparam logic [9:0]  PAGE_VRF       = 10'h001;
	localparam logic [7:0]  PAGE_REGBUF    = 8'h01;
	localparam logic [1:0]  PAGE_SRAM      = 2'h1;

	// =========================================================
	// field positions and reset values
	localparam int          CTL_ENABLE_BIT = 0;
	localparam int          STATE_BUSY_BIT = 31;
	localparam int          WIN_LSB        = 14;
	localparam logic [17:0] WIN_RESET      = 18'h0_0000;

	// =========================================================
	// instruction word fields and codes
	localparam int          OPC_LSB       = 24;
	localparam logic [7:0]  OPC_BEGIN     = 8'h70;
	localparam logic [7:0]  OPC_RESUME    = 8'h71;
	localparam logic [7:0]  OPC_END       = 8'h72;
	localparam logic [3:0]  SEL_LOAD0     = 4'h8;
	localparam logic [3:0]  SEL_LOAD1     = 4'h9;
	localparam logic [3:0]  SEL_STORE     = 4'hC;

	// =========================================================
	// sizes
	localparam int          SRAM_BYTES    = 16384;
	localparam int          REGBUF_BITS   = 2048;
	localparam int          VRF_ENTRIES   = 16;

	typedef enum logic [1:0] {
		DEC_IW0  = 2'b00,
		DEC_ADDR = 2'b01,
		DEC_SIZE = 2'b10
	} cos_dec_t;

	typedef enum logic [1:0] {
		MI_IDLE = 2'b00,
		MI_SRAM = 2'b01,
		MI_EXT  = 2'b10
	} cos_mi_t;

endpackage

//--- hdl/cos_stream.sv
// operand streaming unit: stream instruction decoder, two load streams, one store
// stream, shared memory interface (internal operand SRAM or external master port),
// register buffer, vector register file and a plain register port.
// assumes instruction words, stream consumers/producers and the external memory
// port all run on CLK; the external port answers a request with MEM_ACK.
//
// How it works
// - internal operand SRAM of 16 KB, single-cycle access.
// - one memory interface routes by address[31:14] against window base.
// - register port reads and writes operand SRAM words.
// - stream instructions carry selector and code in 32-bit words.
// - two independent load streams and one store stream.
// - 2048-bit register buffer, reachable from the register port.
// - register buffer cleared on reset and while block disabled.
// - sixteen vector entries, start word address and size in bits.
// - each load stream prefetches bytes into its own buffer.
// - store stream buffers bytes before writing them out.
// - a stream is a start address plus a byte count.
// - begin and end for all streams, resume only for load streams.
// - begin and resume take three words, end takes one.
// - code in word bits 31:24, selector in bits 3:0.
// - begin empties the buffer then streams count bytes from address.
// - illegal selector raises the undefined opcode cause.
// - end discards load buffer, store buffer drains to memory.
// - resume keeps load buffer and fetches from new address.
// - three status registers show each stream's state.
// - selector 8 is load 0, 9 is load 1, 12 store.
`timescale 1ns/1ps
`default_nettype none

module cos_stream #(
	parameter int LD_DEPTH = 8,
	parameter int ST_DEPTH = 8
) (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RST_N,
	// register port
	input  wire logic [15:0] REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [31:0] REG_RDATA,
	// instruction words
	input  wire logic        INSTR_VALID,
	input  wire logic [31:0] INSTR_WORD,
	output logic             INSTR_READY,
	output logic             UNDEFINED_OPCODE_CAUSE,
	// load stream 0
	output logic             LD0_VALID,
	output logic       [7:0] LD0_DATA,
	input  wire logic        LD0_TAKE,
	// load stream 1
	output logic             LD1_VALID,
	output logic       [7:0] LD1_DATA,
	input  wire logic        LD1_TAKE,
	// store stream
	input  wire logic        ST_VALID,
	input  wire logic  [7:0] ST_DATA,
	output logic             ST_READY,
	// external memory port
	output logic             MEM_REQ,
	output logic             MEM_WRITE,
	output logic      [31:0] MEM_ADDR,
	output logic       [7:0] MEM_WDATA,
	input  wire logic        MEM_ACK,
	input  wire logic  [7:0] MEM_RDATA
);

	localparam int LCW = $clog2(LD_DEPTH + 1);
	localparam int SCW = $clog2(ST_DEPTH + 1);
	localparam int SWORDS = cos_pkg::SRAM_BYTES / 4;
	localparam int SIW = $clog2(SWORDS);

	typedef struct packed {
		cos_pkg::cos_dec_t                         dec;
		logic [7:0]                                op;
		logic [3:0]                                sel;
		logic [31:0]                               iaddr;
		logic                                      en;
		logic [17:0]                               win;
		logic [1:0][31:0]                          ld_addr;
		logic [1:0][31:0]                          ld_left;
		logic [1:0][LD_DEPTH-1:0][7:0]             ld_buf;
		logic [1:0][LCW-1:0]                       ld_cnt;
		logic [31:0]                               st_addr;
		logic [31:0]                               st_left;
		logic [ST_DEPTH-1:0][7:0]                  st_buf;
		logic [SCW-1:0]                            st_cnt;
		cos_pkg::cos_mi_t                          mi;
		logic                                      mi_ld1;
		logic [1:0]                                mi_lane;
		logic                                      mem_req;
		logic                                      mem_write;
		logic [31:0]                               mem_addr;
		logic [7:0]                                mem_wdata;
		logic [cos_pkg::VRF_ENTRIES-1:0][31:0]     vrf;
		logic [cos_pkg::REGBUF_BITS-1:0]           regbuf;
		logic [31:0]                               rdata;
		logic                                      rd_sram;
		logic                                      opc_err;
	} cos_state_t;

	cos_state_t s;
	cos_state_t next_s;

	// =========================================================
	// operand SRAM
	// kept outside the state record: a 16 KB array cannot be reset and would
	// swamp the record; one port shared between register port and streams
	logic [31:0]    sram [SWORDS];
	logic [31:0]    sram_q;
	logic           sram_we;
	logic [3:0]     sram_be;
	logic [SIW-1:0] sram_idx;
	logic [31:0]    sram_wd;

	always_ff @(posedge CLK) begin
		if (sram_we) begin
			for (int b = 0; b < 4; b++) begin
				if (sram_be[b]) begin
					sram[sram_idx][b*8 +: 8] <= sram_wd[b*8 +: 8];
				end
			end
		end
		sram_q <= sram[sram_idx];
	end

	// =========================================================
	// decode helpers
	logic       take;
	logic       sl_sram;
	logic       sel_ok;
	logic       exec;
	logic       is_ld;
	logic       li;
	logic [7:0] opw;
	logic [3:0] selw;

	assign opw     = INSTR_WORD[cos_pkg::OPC_LSB +: 8];
	assign selw    = INSTR_WORD[3:0];
	assign take    = INSTR_VALID && INSTR_READY;
	assign sl_sram = (REG_WR || REG_RD) && REG_ADDR[15:14] == cos_pkg::PAGE_SRAM;
	// decoding of the executed instruction: one-word end at IW0, others at IW2
	assign exec    = take && ((s.dec == cos_pkg::DEC_IW0 && opw == cos_pkg::OPC_END)
	                 || s.dec == cos_pkg::DEC_SIZE);
	assign is_ld   = (s.dec == cos_pkg::DEC_IW0) ? (selw == cos_pkg::SEL_LOAD0
	                 || selw == cos_pkg::SEL_LOAD1) : (s.sel == cos_pkg::SEL_LOAD0
	                 || s.sel == cos_pkg::SEL_LOAD1);
	assign li      = (s.dec == cos_pkg::DEC_IW0) ? selw[0] : s.sel[0];
	always_comb begin
		sel_ok = 1'b0;
		unique case (opw)
			cos_pkg::OPC_BEGIN, cos_pkg::OPC_END:
				sel_ok = selw == cos_pkg::SEL_LOAD0 || selw == cos_pkg::SEL_LOAD1
				         || selw == cos_pkg::SEL_STORE;
			cos_pkg::OPC_RESUME:
				sel_ok = selw == cos_pkg::SEL_LOAD0 || selw == cos_pkg::SEL_LOAD1;
			default:
				sel_ok = 1'b0;
		endcase
	end

	// an instruction only executes while the memory interface is between
	// accesses, so no byte is ever in flight for a stream being restarted
	assign INSTR_READY = s.en && s.mi == cos_pkg::MI_IDLE;

	// =========================================================
	// next state
	always_comb begin
		logic          ld_pop  [2];
		logic          st_push;
		logic          push_ld;
		logic [7:0]    push_byte;
		logic [31:0]   a;
		logic          want;
		logic          wr;
		logic          ldsel;
		ld_pop[0] = LD0_TAKE && s.ld_cnt[0] != '0;
		ld_pop[1] = LD1_TAKE && s.ld_cnt[1] != '0;
		st_push   = ST_VALID && ST_READY;
		push_ld   = 1'b0;
		push_byte = 8'h00;
		a         = 32'h0000_0000;
		want      = 1'b0;
		wr        = 1'b0;
		ldsel     = 1'b0;
		sram_we   = 1'b0;
		sram_be   = 4'h0;
		sram_idx  = REG_ADDR[2 +: SIW];
		sram_wd   = REG_WDATA;
		next_s    = s;
		next_s.opc_err = 1'b0;
		next_s.rd_sram = 1'b0;

		// ---------------------------------------------------------
		// register port; it always owns the SRAM in its cycle
		if (sl_sram) begin
			sram_we = REG_WR;
			sram_be = 4'hF;
			next_s.rd_sram = REG_RD;
		end
		if (REG_WR) begin
			if (REG_ADDR == cos_pkg::ADDR_WINDOW) begin
				next_s.win = REG_WDATA[31:cos_pkg::WIN_LSB];
			end
			if (REG_ADDR == cos_pkg::ADDR_CTL) begin
				next_s.en = REG_WDATA[cos_pkg::CTL_ENABLE_BIT];
			end
			if (REG_ADDR[15:6] == cos_pkg::PAGE_VRF) begin
				next_s.vrf[REG_ADDR[5:2]] = REG_WDATA;
			end
			if (REG_ADDR[15:8] == cos_pkg::PAGE_REGBUF) begin
				next_s.regbuf[REG_ADDR[7:2]*32 +: 32] = REG_WDATA;
			end
		end
		if (REG_RD) begin
			next_s.rdata = 32'h0000_0000;
			for (int i = 0; i < 2; i++) begin
				if (REG_ADDR == (i == 0 ? cos_pkg::ADDR_LD0_STATE : cos_pkg::ADDR_LD1_STATE)) begin
					next_s.rdata[cos_pkg::STATE_BUSY_BIT] = s.ld_left[i] != '0;
					next_s.rdata[LCW-1:0] = s.ld_cnt[i];
				end
			end
			if (REG_ADDR == cos_pkg::ADDR_ST_STATE) begin
				next_s.rdata[cos_pkg::STATE_BUSY_BIT] = s.st_left != '0 || s.st_cnt != '0;
				next_s.rdata[SCW-1:0] = s.st_cnt;
			end
			if (REG_ADDR == cos_pkg::ADDR_WINDOW) begin
				next_s.rdata[31:cos_pkg::WIN_LSB] = s.win;
			end
			if (REG_ADDR == cos_pkg::ADDR_CTL) begin
				next_s.rdata[cos_pkg::CTL_ENABLE_BIT] = s.en;
			end
			if (REG_ADDR[15:6] == cos_pkg::PAGE_VRF) begin
				next_s.rdata = s.vrf[REG_ADDR[5:2]];
			end
			if (REG_ADDR[15:8] == cos_pkg::PAGE_REGBUF) begin
				next_s.rdata = s.regbuf[REG_ADDR[7:2]*32 +: 32];
			end
		end

		// ---------------------------------------------------------
		// consumers and producer
		for (int i = 0; i < 2; i++) begin
			if (ld_pop[i]) begin
				next_s.ld_buf[i] = s.ld_buf[i] >> 8;
				next_s.ld_cnt[i] = s.ld_cnt[i] - 1'b1;
			end
		end

		// ---------------------------------------------------------
		// memory interface: store drain first, then load 0, then load 1
		unique case (s.mi)
			cos_pkg::MI_IDLE: begin
				if (!exec) begin
					if (s.st_cnt != '0) begin
						want = 1'b1;
						wr   = 1'b1;
						a    = s.st_addr;
					end else if (s.ld_left[0] != '0 && s.ld_cnt[0] < LCW'(LD_DEPTH)) begin
						want = 1'b1;
						a    = s.ld_addr[0];
					end else if (s.ld_left[1] != '0 && s.ld_cnt[1] < LCW'(LD_DEPTH)) begin
						want  = 1'b1;
						ldsel = 1'b1;
						a     = s.ld_addr[1];
					end
				end
				if (want && a[31:cos_pkg::WIN_LSB] == s.win) begin
					if (!sl_sram) begin
						sram_idx = a[2 +: SIW];
						sram_wd  = {4{s.st_buf[0]}};
						sram_be  = 4'h1 << a[1:0];
						if (wr) begin
							sram_we        = 1'b1;
							next_s.st_addr = s.st_addr + 32'h0000_0001;
							next_s.st_buf  = s.st_buf >> 8;
							next_s.st_cnt  = s.st_cnt - 1'b1;
						end else begin
							next_s.mi      = cos_pkg::MI_SRAM;
							next_s.mi_ld1  = ldsel;
							next_s.mi_lane = a[1:0];
						end
					end
				end else if (want) begin
					next_s.mi        = cos_pkg::MI_EXT;
					next_s.mi_ld1    = ldsel;
					next_s.mem_req   = 1'b1;
					next_s.mem_write = wr;
					next_s.mem_addr  = a;
					next_s.mem_wdata = s.st_buf[0];
				end
			end
			cos_pkg::MI_SRAM: begin
				push_ld   = 1'b1;
				push_byte = sram_q[s.mi_lane*8 +: 8];
				next_s.mi = cos_pkg::MI_IDLE;
			end
			cos_pkg::MI_EXT: begin
				if (MEM_ACK) begin
					next_s.mem_req = 1'b0;
					next_s.mi      = cos_pkg::MI_IDLE;
					if (s.mem_write) begin
						next_s.st_addr = s.st_addr + 32'h0000_0001;
						next_s.st_buf  = s.st_buf >> 8;
						next_s.st_cnt  = s.st_cnt - 1'b1;
					end else begin
						push_ld   = 1'b1;
						push_byte = MEM_RDATA;
					end
				end
			end
			default: begin
				next_s.mi = cos_pkg::MI_IDLE;
			end
		endcase

		// store push comes after the drain pop so the slot index is current
		if (st_push) begin
			next_s.st_buf[next_s.st_cnt] = ST_DATA;
			next_s.st_cnt  = next_s.st_cnt + 1'b1;
			next_s.st_left = s.st_left - 32'h0000_0001;
		end
		if (push_ld) begin
			next_s.ld_buf[s.mi_ld1][next_s.ld_cnt[s.mi_ld1]] = push_byte;
			next_s.ld_cnt[s.mi_ld1]  = next_s.ld_cnt[s.mi_ld1] + 1'b1;
			next_s.ld_addr[s.mi_ld1] = s.ld_addr[s.mi_ld1] + 32'h0000_0001;
			next_s.ld_left[s.mi_ld1] = s.ld_left[s.mi_ld1] - 32'h0000_0001;
		end

		// ---------------------------------------------------------
		// instruction decoder
		if (take) begin
			unique case (s.dec)
				cos_pkg::DEC_IW0: begin
					next_s.op  = opw;
					next_s.sel = selw;
					next_s.opc_err = !sel_ok;
					if (opw == cos_pkg::OPC_BEGIN || opw == cos_pkg::OPC_RESUME) begin
						next_s.dec = cos_pkg::DEC_ADDR;
					end
					if (opw == cos_pkg::OPC_END && sel_ok) begin
						if (is_ld) begin
							next_s.ld_buf[li]  = '0;
							next_s.ld_cnt[li]  = '0;
							next_s.ld_left[li] = '0;
						end else begin
							next_s.st_left = '0;
						end
					end
				end
				cos_pkg::DEC_ADDR: begin
					next_s.iaddr = INSTR_WORD;
					next_s.dec   = cos_pkg::DEC_SIZE;
				end
				cos_pkg::DEC_SIZE: begin
					next_s.dec = cos_pkg::DEC_IW0;
					// an illegal selector was flagged at the first word; the
					// remaining words are only swallowed to keep alignment
					if (s.op == cos_pkg::OPC_BEGIN && !is_ld && s.sel == cos_pkg::SEL_STORE) begin
						next_s.st_buf  = '0;
						next_s.st_cnt  = '0;
						next_s.st_addr = s.iaddr;
						next_s.st_left = INSTR_WORD;
					end
					if (is_ld && (s.op == cos_pkg::OPC_BEGIN || s.op == cos_pkg::OPC_RESUME)) begin
						if (s.op == cos_pkg::OPC_BEGIN) begin
							next_s.ld_buf[li] = '0;
							next_s.ld_cnt[li] = '0;
						end
						// resume leaves buffered bytes in place
						next_s.ld_addr[li] = s.iaddr;
						next_s.ld_left[li] = INSTR_WORD;
					end
				end
				default: begin
					next_s.dec = cos_pkg::DEC_IW0;
				end
			endcase
		end

		// block disable clears the register buffer, decoder, stream counts and memory interface; configuration and the vector file stay
		if (!s.en) begin
			next_s.regbuf  = '0;
			next_s.dec     = cos_pkg::DEC_IW0;
			next_s.ld_left = '0;
			next_s.ld_cnt  = '0;
			next_s.st_left = '0;
			next_s.st_cnt  = '0;
			next_s.mi      = cos_pkg::MI_IDLE;
			next_s.mem_req = 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			s     <= '0;
			s.win <= cos_pkg::WIN_RESET;
		end else begin
			s <= next_s;
		end
	end

	// =========================================================
	// outputs
	assign REG_RDATA              = s.rd_sram ? sram_q : s.rdata;
	assign UNDEFINED_OPCODE_CAUSE = s.opc_err;
	assign LD0_VALID              = s.ld_cnt[0] != '0;
	assign LD0_DATA               = s.ld_buf[0][0];
	assign LD1_VALID              = s.ld_cnt[1] != '0;
	assign LD1_DATA               = s.ld_buf[1][0];
	assign ST_READY               = s.en && s.st_left != '0 && s.st_cnt < SCW'(ST_DEPTH);
	assign MEM_REQ                = s.mem_req;
	assign MEM_WRITE              = s.mem_write;
	assign MEM_ADDR               = s.mem_addr;
	assign MEM_WDATA              = s.mem_wdata;

	// =========================================================
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	chk_regbuf_clear: assert property (!s.en |=> s.regbuf == '0)
		else $error("register buffer not cleared while disabled");
	chk_bad_selector: assert property (take && s.dec == cos_pkg::DEC_IW0 && !sel_ok
		|=> UNDEFINED_OPCODE_CAUSE ##1 !UNDEFINED_OPCODE_CAUSE)
		else $error("illegal selector did not pulse the undefined opcode cause");
	chk_begin_load: assert property (take && s.dec == cos_pkg::DEC_SIZE
		&& s.op == cos_pkg::OPC_BEGIN && s.sel == cos_pkg::SEL_LOAD0 && s.en
		|=> s.ld_left[0] == $past(INSTR_WORD) && !LD0_VALID)
		else $error("begin did not empty load stream 0 and load its count");
	chk_resume_load: assert property (take && s.dec == cos_pkg::DEC_SIZE
		&& s.op == cos_pkg::OPC_RESUME && s.sel == cos_pkg::SEL_LOAD1 && s.en
		&& s.ld_cnt[1] != '0 && !LD1_TAKE |=> LD1_VALID && s.ld_addr[1] == $past(s.iaddr))
		else $error("resume lost buffered bytes or address");
	chk_end_load: assert property (take && s.dec == cos_pkg::DEC_IW0
		&& opw == cos_pkg::OPC_END && selw == cos_pkg::SEL_LOAD0
		|=> !LD0_VALID && s.ld_left[0] == '0)
		else $error("end did not discard load stream 0");
	chk_ext_route: assert property ($rose(MEM_REQ)
		|-> MEM_ADDR[31:cos_pkg::WIN_LSB] != s.win)
		else $error("external request issued for a window address");
	chk_ext_hold: assert property (MEM_REQ && !MEM_ACK
		|=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WRITE))
		else $error("external request dropped before acknowledge");
	chk_store_ready: assert property (take && s.dec == cos_pkg::DEC_IW0
		&& opw == cos_pkg::OPC_END && selw == cos_pkg::SEL_STORE
		|=> !ST_READY && s.st_left == '0)
		else $error("store stream still accepts bytes after end");
	chk_ld_busy_read: assert property (REG_RD && REG_ADDR == cos_pkg::ADDR_LD0_STATE
		|=> REG_RDATA[cos_pkg::STATE_BUSY_BIT] == ($past(s.ld_left[0]) != '0))
		else $error("load stream 0 busy flag misreported");

endmodule

`default_nettype wire

//--- tb/cos_mem_model.sv
// system memory model behind the external master port of the streaming unit
// assumes one byte per request, request held until a same-clock acknowledge
`timescale 1ns/1ps
`default_nettype none

module cos_mem_model (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RST_N,
	// master port
	input  wire logic        MEM_REQ,
	input  wire logic        MEM_WRITE,
	input  wire logic [31:0] MEM_ADDR,
	input  wire logic  [7:0] MEM_WDATA,
	output logic             MEM_ACK,
	output logic       [7:0] MEM_RDATA,
	// bench view
	input  wire logic        SLOW,
	output logic       [7:0] WR_COUNT,
	output logic      [31:0] WR_ADDR,
	output logic       [7:0] WR_DATA
);
	logic [1:0] wait_cnt;

	// =========================================================
	// answer: read byte is a pattern of the address, only valid beside the acknowledge;
	// otherwise it flips every cycle so a late sample never matches by luck
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			wait_cnt  <= 2'h0;
			MEM_ACK   <= 1'b0;
			MEM_RDATA <= 8'h00;
			WR_COUNT  <= 8'h00;
			WR_ADDR   <= 32'h0000_0000;
			WR_DATA   <= 8'h00;
		end else begin
			MEM_ACK   <= 1'b0;
			MEM_RDATA <= ~MEM_RDATA;
			if (MEM_REQ && !MEM_ACK) begin
				if (wait_cnt != (SLOW ? 2'h3 : 2'h0)) begin
					wait_cnt <= wait_cnt + 2'h1;
				end else begin
					wait_cnt  <= 2'h0;
					MEM_ACK   <= 1'b1;
					MEM_RDATA <= MEM_ADDR[7:0] ^ 8'hA5;
					if (MEM_WRITE) begin
						WR_COUNT <= WR_COUNT + 8'h01;
						WR_ADDR  <= MEM_ADDR;
						WR_DATA  <= MEM_WDATA;
					end
				end
			end
		end
	end
endmodule

`default_nettype wire

//--- tb/cos_stream_tb_top.sv
// self-checking bench for the operand streaming unit
// assumes window base 0, so addresses below 0x4000 hit the operand SRAM
`timescale 1ns/1ps
`default_nettype none

module cos_stream_tb_top;
	logic CLK = 1'b0, RST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, INSTR_VALID = 1'b0;
	logic [15:0] REG_ADDR = 16'h0000;
	logic [31:0] REG_WDATA = 32'h0000_0000, INSTR_WORD = 32'h0000_0000, REG_RDATA, MEM_ADDR;
	logic LD0_TAKE = 1'b0, LD1_TAKE = 1'b0, ST_VALID = 1'b0, SLOW = 1'b0;
	logic [7:0] ST_DATA = 8'h00, LD0_DATA, LD1_DATA, MEM_WDATA, MEM_RDATA, WR_COUNT, WR_DATA;
	logic INSTR_READY, UNDEFINED_OPCODE_CAUSE, LD0_VALID, LD1_VALID, ST_READY;
	logic MEM_REQ, MEM_WRITE, MEM_ACK;
	logic [31:0] WR_ADDR;
	int err_count = 0;
	int samples_checked = 0;
	int cause_cnt = 0;

	always #20 CLK = ~CLK;
	always @(negedge CLK) if (UNDEFINED_OPCODE_CAUSE === 1'b1) cause_cnt++;

	cos_stream #(.LD_DEPTH(8), .ST_DEPTH(8)) u_cos_stream (.CLK(CLK), .RST_N(RST_N),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_RDATA(REG_RDATA), .INSTR_VALID(INSTR_VALID), .INSTR_WORD(INSTR_WORD),
		.INSTR_READY(INSTR_READY), .UNDEFINED_OPCODE_CAUSE(UNDEFINED_OPCODE_CAUSE),
		.LD0_VALID(LD0_VALID), .LD0_DATA(LD0_DATA), .LD0_TAKE(LD0_TAKE),
		.LD1_VALID(LD1_VALID), .LD1_DATA(LD1_DATA), .LD1_TAKE(LD1_TAKE),
		.ST_VALID(ST_VALID), .ST_DATA(ST_DATA), .ST_READY(ST_READY), .MEM_REQ(MEM_REQ),
		.MEM_WRITE(MEM_WRITE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
		.MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA));
	cos_mem_model u_cos_mem_model (.CLK(CLK), .RST_N(RST_N), .MEM_REQ(MEM_REQ),
		.MEM_WRITE(MEM_WRITE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
		.MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .SLOW(SLOW), .WR_COUNT(WR_COUNT),
		.WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA));

	// =========================================================
	// reporting
	task automatic test_done;
		$display("comparisons %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stuck;
		err_count++;
		$display("unexpected at %0t: got %h expected %h (wait ran out)", $time, 1'b0, 1'b1);
		test_done();
	endtask
	initial begin
		repeat (20000) @(posedge CLK);
		stuck();
	end

	// =========================================================
	// register port and instruction words
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge CLK);
		REG_ADDR <= a; REG_WDATA <= d; REG_WR <= 1'b1;
		@(posedge CLK);
		REG_WR <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		@(posedge CLK);
		REG_ADDR <= a; REG_RD <= 1'b1;
		@(posedge CLK);
		REG_RD <= 1'b0;
		#1 d = REG_RDATA;
	endtask
	task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chk(d, exp);
	endtask
	// polls the state word until busy drops; returns the settled word
	task automatic idle(input logic [15:0] a, output logic [31:0] d);
		int k;
		k = 0;
		do begin rd(a, d); k++; end while (d[31] !== 1'b0 && k < 40);
		if (d[31] !== 1'b0) stuck();
	endtask
	function automatic logic [31:0] iw(input logic [7:0] op, input logic [3:0] sel);
		return {op, 20'h0_0000, sel};
	endfunction
	task automatic issue(input logic [31:0] w0, w1, w2, input int n);
		logic [31:0] w [3];
		int k;
		w = '{w0, w1, w2};
		@(posedge CLK);
		for (int i = 0; i < n; i++) begin
			INSTR_WORD <= w[i]; INSTR_VALID <= 1'b1;
			k = 0;
			do begin @(negedge CLK); k++; end while (INSTR_READY !== 1'b1 && k < 40);
			if (INSTR_READY !== 1'b1) stuck();
			@(posedge CLK);
		end
		INSTR_VALID <= 1'b0;
	endtask

	// =========================================================
	// stream consumer and producer
	task automatic pop(input logic ld1, input logic [7:0] exp);
		int k;
		k = 0;
		do begin @(negedge CLK); k++; end while ((ld1 ? LD1_VALID : LD0_VALID) !== 1'b1 && k < 40);
		if ((ld1 ? LD1_VALID : LD0_VALID) !== 1'b1) stuck();
		chk({24'h00_0000, ld1 ? LD1_DATA : LD0_DATA}, {24'h00_0000, exp});
		@(posedge CLK);
		if (ld1) LD1_TAKE <= 1'b1; else LD0_TAKE <= 1'b1;
		@(posedge CLK);
		LD0_TAKE <= 1'b0; LD1_TAKE <= 1'b0;
	endtask
	task automatic push(input logic [7:0] b);
		int k;
		@(posedge CLK);
		ST_VALID <= 1'b1; ST_DATA <= b;
		k = 0;
		do begin @(negedge CLK); k++; end while (ST_READY !== 1'b1 && k < 40);
		if (ST_READY !== 1'b1) stuck();
		@(posedge CLK);
		ST_VALID <= 1'b0;
	endtask

	// =========================================================
	// main sequence
	initial begin
		logic [31:0] d;
		int c0;
		repeat (20) @(posedge CLK);
		RST_N <= 1'b1;
		rdc(cos_pkg::ADDR_WINDOW, 32'h0000_0000);
		rdc(16'h0020, 32'h0000_0000);
		chk({31'h0000_0000, INSTR_READY}, 32'h0000_0000);
		$display("test reset done");
		wr(cos_pkg::ADDR_CTL, 32'h0000_0001);
		wr(16'h0104, 32'hDEAD_BEEF);
		wr(16'h0048, 32'h1234_5678);
		wr(16'h4000, 32'h4433_2211);
		wr(16'h4008, 32'h0000_0000);
		rdc(16'h0104, 32'hDEAD_BEEF);
		rdc(16'h0048, 32'h1234_5678);
		rdc(16'h4000, 32'h4433_2211);
		wr(cos_pkg::ADDR_CTL, 32'h0000_0000);
		wr(cos_pkg::ADDR_CTL, 32'h0000_0001);
		rdc(16'h0104, 32'h0000_0000);
		$display("test registers done");
		// sram-backed load: all four bytes prefetched before any is taken
		issue(iw(cos_pkg::OPC_BEGIN, cos_pkg::SEL_LOAD0), 32'h0000_0000, 32'h0000_0004, 3);
		idle(cos_pkg::ADDR_LD0_STATE, d);
		chk(d, 32'h0000_0004);
		for (int i = 0; i < 4; i++) pop(1'b0, 8'(8'h11 * (i + 1)));
		$display("test load sram done");
		// external load with a slow memory, then resume keeping the buffer
		SLOW <= 1'b1;
		issue(iw(cos_pkg::OPC_BEGIN, cos_pkg::SEL_LOAD1), 32'h0001_0000, 32'h0000_0003, 3);
		idle(cos_pkg::ADDR_LD1_STATE, d);
		chk(d, 32'h0000_0003);
		issue(iw(cos_pkg::OPC_RESUME, cos_pkg::SEL_LOAD1), 32'h0002_0040, 32'h0000_0002, 3);
		for (int i = 0; i < 3; i++) pop(1'b1, i[7:0] ^ 8'hA5);
		for (int i = 0; i < 2; i++) pop(1'b1, (8'h40 + i[7:0]) ^ 8'hA5);
		$display("test load resume done");
		// end on a load buffer holding all four prefetched bytes throws the bytes away
		issue(iw(cos_pkg::OPC_BEGIN, cos_pkg::SEL_LOAD0), 32'h0000_0000, 32'h0000_0004, 3);
		idle(cos_pkg::ADDR_LD0_STATE, d);
		issue(iw(cos_pkg::OPC_END, cos_pkg::SEL_LOAD0), 32'h0000_0000, 32'h0000_0000, 1);
		rdc(cos_pkg::ADDR_LD0_STATE, 32'h0000_0000);
		chk({31'h0000_0000, LD0_VALID}, 32'h0000_0000);
		$display("test load end done");
		// moved window: 0x4000 now hits the operand SRAM instead of the master port
		wr(cos_pkg::ADDR_WINDOW, 32'h0000_4000);
		rdc(cos_pkg::ADDR_WINDOW, 32'h0000_4000);
		issue(iw(cos_pkg::OPC_BEGIN, cos_pkg::SEL_LOAD0), 32'h0000_4000, 32'h0000_0001, 3);
		pop(1'b0, 8'h11);
		wr(cos_pkg::ADDR_WINDOW, 32'h0000_0000);
		$display("test window done");
		// store to external memory with stalls, then short store to sram ended early
		issue(iw(cos_pkg::OPC_BEGIN, cos_pkg::SEL_STORE), 32'h0003_0010, 32'h0000_0003, 3);
		push(8'h5C);
		push(8'h6D);
		// end while the second byte still waits in the buffer: it must be flushed
		issue(iw(cos_pkg::OPC_END, cos_pkg::SEL_STORE), 32'h0000_0000, 32'h0000_0000, 1);
		idle(cos_pkg::ADDR_ST_STATE, d);
		chk({WR_COUNT, WR_DATA, 16'h0000}, 32'h026D_0000);
		chk(WR_ADDR, 32'h0003_0011);
		SLOW <= 1'b0;
		issue(iw(cos_pkg::OPC_BEGIN, cos_pkg::SEL_STORE), 32'h0000_0008, 32'h0000_0004, 3);
		for (int i = 1; i < 4; i++) push(8'(8'hA0 + 8'h11 * i));
		issue(iw(cos_pkg::OPC_END, cos_pkg::SEL_STORE), 32'h0000_0000, 32'h0000_0000, 1);
		idle(cos_pkg::ADDR_ST_STATE, d);
		chk({31'h0000_0000, ST_READY}, 32'h0000_0000);
		rdc(16'h4008, 32'h00D3_C2B1);
		$display("test store done");
		// illegal selectors and an unknown code each raise the cause once
		c0 = cause_cnt;
		issue(iw(cos_pkg::OPC_BEGIN, 4'hA), 32'h0000_0000, 32'h0000_0001, 3);
		issue(iw(cos_pkg::OPC_RESUME, cos_pkg::SEL_STORE), 32'h0000_0000, 32'h0000_0001, 3);
		issue(iw(cos_pkg::OPC_END, 4'h3), 32'h0000_0000, 32'h0000_0000, 1);
		issue(iw(8'h73, cos_pkg::SEL_LOAD0), 32'h0000_0000, 32'h0000_0000, 1);
		repeat (3) @(posedge CLK);
		chk(cause_cnt - c0, 32'h0000_0004);
		rdc(cos_pkg::ADDR_ST_STATE, 32'h0000_0000);
		$display("test illegal done");
		test_done();
	end
endmodule

`default_nettype wire
